// ### verilog/aprr_map.svh
`ifndef APRR_MAP_SVH
`define APRR_MAP_SVH

// ============================================================
// result word layout
`define APRR_CHANNELS    8
`define APRR_CODE_W      14
`define APRR_WORD_W      16
`define APRR_PAD_W       2
`define APRR_BYTE_W      8
`define APRR_BYTES       16

// ============================================================
// buffering
`define APRR_FIFO_W      14
`define APRR_FIFO_DEPTH  8

// ============================================================
// reset pin values: strobes idle high, all else low; output enable codes
`define APRR_PINS_RST    6'h30
`define APRR_OE_WIDE     2'h3
`define APRR_OE_BYTE     2'h1
`define APRR_OE_OFF      2'h0

// ============================================================
// timing
`define APRR_CLK_NS      50
`define APRR_TCONV_NS    4000

`endif

// ### verilog/aprr_pkg.sv
`include "aprr_map.svh"

package aprr_pkg;

    // ========================================================
    // interface modes
    typedef enum logic [1:0] {
        MODE_PAR,
        MODE_BYTE,
        MODE_SER,
        MODE_BAD
    } aprr_mode_t;

    // ========================================================
    // pin sample group
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic busy;
        logic sel_p;
        logic sel_s;
        logic order;
    } aprr_pins_t;

    // ========================================================
    // readout state
    typedef struct packed {
        aprr_pins_t                                   s1;
        aprr_pins_t                                   s2;
        aprr_pins_t                                   s3;
        aprr_mode_t                                   mode;
        logic [`APRR_CHANNELS-1:0][`APRR_WORD_W-1:0]  result;
        logic [`APRR_CHANNELS-1:0][`APRR_WORD_W-1:0]  stage;
        logic [3:0]                                   stage_cnt;
        logic [3:0]                                   ptr;
        logic [`APRR_WORD_W-1:0]                      bus;
        logic [1:0]                                   bus_oe;
        logic                                         first;
        logic                                         first_oe;
        logic                                         busy_o;
        logic [15:0]                                  conv_cnt;
        logic                                         overrun;
    } aprr_state_t;

endpackage

// ### verilog/aprr_fifo.sv
`timescale 1ns/1ps

module aprr_fifo #(
    parameter int W     = 14,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    in_ready;
    } aprr_fifo_state_t;

    aprr_fifo_state_t q;
    aprr_fifo_state_t n;
    logic             push;
    logic             pop;

    // ========================================================
    // ports
    assign in_ready  = q.in_ready;
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid & q.in_ready;
    assign pop       = out_valid & out_ready;

    // ========================================================
    // next state
    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wp] = in_data;
            n.wp        = q.wp + 1'b1;
        end
        if (pop) begin
            n.rp = q.rp + 1'b1;
        end
        n.cnt      = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        n.in_ready = (n.cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
        q.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");

endmodule

// ### verilog/aprr_readout.sv
//
// Contract
// - busy fall loads code plus two zeros
// - read after busy low gives new sample
// - read during busy gives previous sample
// - two select pins choose interface mode
// - parallel mode drives sixteen-line result bus
// - combined strobe fall drives bus out
// - combined strobe: channel 1 first, flag high; code gives channel 1 only when the read pointer is at zero
// - separate strobes: select fall enables bus
// - separate: first read gives channel 1
// - parallel flag low from second read
// - byte mode: two byte transfers per channel
// - order pin high sends upper byte first
// - byte mode select fall enables bus
// - each read advances one byte, sixteen
// - byte flag high two reads, low after
// - busy high no longer than conversion time; longer busy passes through, sets conv_overrun
// - strobes high return bus to float
`timescale 1ns/1ps
`include "aprr_map.svh"

module aprr_readout #(
    parameter int TCONV_NS   = `APRR_TCONV_NS,
    parameter int FIFO_DEPTH = `APRR_FIFO_DEPTH
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      cs_n,
    input  wire logic                      rd_n,
    input  wire logic                      busy_in,
    input  wire logic                      interface_select_primary,
    input  wire logic                      interface_select_secondary,
    input  wire logic                      byte_order_select,
    input  wire logic [`APRR_CODE_W-1:0]   code_data,
    input  wire logic                      code_valid,
    output logic                           code_ready,
    output logic [`APRR_WORD_W-1:0]        result_bus,
    output logic [1:0]                     result_bus_oe,
    output logic                           first_channel_flag,
    output logic                           first_channel_flag_oe,
    output logic                           busy_out,
    output logic                           conv_overrun
);

    // ========================================================
    // timing
    localparam int TCONV_CYC_RAW = TCONV_NS / `APRR_CLK_NS;
    localparam int TCONV_CYC     = (TCONV_CYC_RAW < 1) ? 1 : TCONV_CYC_RAW;

    aprr_pkg::aprr_state_t q;
    aprr_pkg::aprr_state_t n;
    aprr_pkg::aprr_pins_t  pins;
    aprr_pkg::aprr_mode_t  mode_dec;

    logic [`APRR_CODE_W-1:0] fifo_data;
    logic                    fifo_valid;
    logic                    fifo_take;
    logic                    cs_fall;
    logic                    cs_rise;
    logic                    rd_fall;
    logic                    busy_fall;
    logic                    busy_rise;
    logic [3:0]              ptr_base;
    logic [`APRR_WORD_W-1:0] rd_word;
    logic [`APRR_WORD_W-1:0] byte_word;
    logic                    hi_first;

    // ========================================================
    // code buffer between converter and staging
    aprr_fifo #(
        .W     (`APRR_FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (code_data),
        .in_valid  (code_valid),
        .in_ready  (code_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );

    // ========================================================
    // pin grouping and edges
    assign pins.cs_n  = cs_n;
    assign pins.rd_n  = rd_n;
    assign pins.busy  = busy_in;
    assign pins.sel_p = interface_select_primary;
    assign pins.sel_s = interface_select_secondary;
    assign pins.order = byte_order_select;

    assign cs_fall   = q.s3.cs_n & ~q.s2.cs_n;
    assign cs_rise   = ~q.s3.cs_n & q.s2.cs_n;
    assign rd_fall   = q.s3.rd_n & ~q.s2.rd_n & ~q.s2.cs_n;
    assign busy_fall = q.s3.busy & ~q.s2.busy;
    assign busy_rise = ~q.s3.busy & q.s2.busy;

    // staging accepts only while a conversion runs
    assign fifo_take = q.s2.busy & (q.stage_cnt < 4'(`APRR_CHANNELS));

    // restart point of the read pointer
    // tied strobes step on, a bare select fall restarts
    assign ptr_base = (busy_fall | (cs_fall & ~rd_fall)) ? 4'h0
                                                         : q.ptr;

    assign rd_word   = q.result[ptr_base[2:0]];
    assign byte_word = q.result[ptr_base[3:1]];
    assign hi_first  = q.s2.order ^ ptr_base[0];

    // ========================================================
    // mode decode
    always_comb begin
        case ({q.s2.sel_p, q.s2.sel_s})
            2'h0:    mode_dec = aprr_pkg::MODE_PAR;
            2'h3:    mode_dec = aprr_pkg::MODE_BYTE;
            2'h2:    mode_dec = aprr_pkg::MODE_SER;
            default: mode_dec = aprr_pkg::MODE_BAD;
        endcase
    end

    // ========================================================
    // next state
    always_comb begin
        n      = q;
        n.s1   = pins;
        n.s2   = q.s1;
        n.s3   = q.s2;
        n.mode = mode_dec;

        // staging of the conversion in progress
        if (fifo_valid & fifo_take) begin
            n.stage[q.stage_cnt[2:0]] = {fifo_data,
                                         {`APRR_PAD_W{1'b0}}};
            n.stage_cnt = q.stage_cnt + 4'h1;
        end

        // result set only changes at end of conversion
        if (busy_fall) begin
            n.result    = q.stage;
            n.stage_cnt = 4'h0;
        end
        n.ptr = ptr_base;

        // frame start enables this device's outputs in parallel and byte modes only
        if (cs_fall) begin
            n.first    = 1'b0;
            n.first_oe = (q.mode == aprr_pkg::MODE_PAR) |
                         (q.mode == aprr_pkg::MODE_BYTE);
            case (q.mode)
                aprr_pkg::MODE_PAR:  n.bus_oe = `APRR_OE_WIDE;
                aprr_pkg::MODE_BYTE: n.bus_oe = `APRR_OE_BYTE;
                default:             n.bus_oe = `APRR_OE_OFF;
            endcase
        end

        // read strobe presents the next item
        if (rd_fall) begin
            case (q.mode)
                aprr_pkg::MODE_PAR: begin
                    n.bus   = rd_word;
                    n.first = (ptr_base == 4'h0);
                    n.ptr   = {1'b0, ptr_base[2:0] + 3'h1};
                end
                aprr_pkg::MODE_BYTE: begin
                    n.bus[15:8] = 8'h00;
                    n.bus[7:0]  = hi_first ? byte_word[15:8]
                                           : byte_word[7:0];
                    n.first     = (ptr_base < 4'h2);
                    n.ptr       = ptr_base + 4'h1;
                end
                default: begin
                    n.ptr = ptr_base;
                end
            endcase
        end

        // frame end floats bus and flag
        if (cs_rise) begin
            n.bus_oe   = `APRR_OE_OFF;
            n.first_oe = 1'b0;
            n.first    = 1'b0;
        end

        // conversion time watch
        n.busy_o = q.s2.busy;
        if (busy_rise) begin
            n.conv_cnt = 16'h0000;
            n.overrun  = 1'b0;
        end else if (q.s2.busy) begin
            if (q.conv_cnt != 16'hFFFF) begin
                n.conv_cnt = q.conv_cnt + 16'h0001;
            end
            if (q.conv_cnt >= 16'(TCONV_CYC)) begin
                n.overrun = 1'b1;
            end
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q      <= '0;
            q.s1   <= `APRR_PINS_RST;
            q.s2   <= `APRR_PINS_RST;
            q.s3   <= `APRR_PINS_RST;
        end else begin
            q <= n;
        end
    end

    // ========================================================
    // outputs
    assign result_bus            = q.bus;
    assign result_bus_oe         = q.bus_oe;
    assign first_channel_flag    = q.first;
    assign first_channel_flag_oe = q.first_oe;
    assign busy_out              = q.busy_o;
    assign conv_overrun          = q.overrun;

    // ========================================================
    // checks
    result_load_a: assert property (@(posedge clk) disable iff (rst)
        busy_fall |=> (q.result == $past(q.stage)))
        else $error("result set not loaded at busy fall");

    result_hold_a: assert property (@(posedge clk) disable iff (rst)
        !busy_fall |=> $stable(q.result))
        else $error("result set changed outside busy fall");

    par_data_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && q.mode == aprr_pkg::MODE_PAR)
        |=> (result_bus == $past(rd_word)))
        else $error("parallel read gave wrong word");

    par_enable_a: assert property (@(posedge clk) disable iff (rst)
        (cs_fall && q.mode == aprr_pkg::MODE_PAR)
        |=> (result_bus_oe == 2'h3) && first_channel_flag_oe)
        else $error("parallel bus not enabled at select fall");

    par_first_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && cs_fall && q.mode == aprr_pkg::MODE_PAR
         && ptr_base == 4'h0)
        |=> first_channel_flag && (result_bus == $past(q.result[0])))
        else $error("combined strobe did not give channel 1");

    par_flag_low_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && q.mode == aprr_pkg::MODE_PAR && ptr_base != 4'h0)
        |=> !first_channel_flag)
        else $error("parallel flag high past first read");

    byte_flag_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && q.mode == aprr_pkg::MODE_BYTE)
        |=> (first_channel_flag == ($past(ptr_base) < 4'h2)))
        else $error("byte flag wrong for byte index");

    byte_order_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && q.mode == aprr_pkg::MODE_BYTE && !ptr_base[0]
         && q.s2.order)
        |=> (result_bus[7:0] == $past(byte_word[15:8])))
        else $error("upper byte not first with order high");

    byte_step_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && q.mode == aprr_pkg::MODE_BYTE)
        |=> (q.ptr == $past(ptr_base) + 4'h1))
        else $error("byte pointer did not advance by one");

    frame_end_a: assert property (@(posedge clk) disable iff (rst)
        cs_rise |=> (result_bus_oe == 2'h0) && !first_channel_flag_oe)
        else $error("outputs still driven after select rise");

    ptr_restart_a: assert property (@(posedge clk) disable iff (rst)
        ((busy_fall || cs_fall) && !rd_fall) |=> (q.ptr == 4'h0))
        else $error("pointer not restarted");

    serial_quiet_a: assert property (@(posedge clk) disable iff (rst)
        (cs_fall && q.mode == aprr_pkg::MODE_SER)
        |=> (result_bus_oe == 2'h0))
        else $error("bus driven in serial mode");

    overrun_a: assert property (@(posedge clk) disable iff (rst)
        (q.s2.busy && !busy_rise && q.conv_cnt >= 16'(TCONV_CYC))
        |=> conv_overrun)
        else $error("long busy not flagged");

    par_step_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && q.mode == aprr_pkg::MODE_PAR)
        |=> (q.ptr == {1'b0, $past(ptr_base[2:0]) + 3'h1}))
        else $error("parallel pointer did not step");

    tied_next_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && cs_fall && q.mode == aprr_pkg::MODE_PAR
         && ptr_base != 4'h0)
        |=> !first_channel_flag && (result_bus == $past(rd_word)))
        else $error("tied strobe did not give next channel");

    byte_enable_a: assert property (@(posedge clk) disable iff (rst)
        (cs_fall && q.mode == aprr_pkg::MODE_BYTE)
        |=> (result_bus_oe == 2'h1) && first_channel_flag_oe)
        else $error("byte bus not enabled at select fall");

    byte_upper_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && q.mode == aprr_pkg::MODE_BYTE)
        |=> (result_bus[15:8] == 8'h00))
        else $error("byte mode drove upper lines");

    byte_swap_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && q.mode == aprr_pkg::MODE_BYTE && !ptr_base[0]
         && !q.s2.order)
        |=> (result_bus[7:0] == $past(byte_word[7:0])))
        else $error("lower byte not first with order low");

    byte_second_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fall && q.mode == aprr_pkg::MODE_BYTE && ptr_base[0]
         && q.s2.order)
        |=> (result_bus[7:0] == $past(byte_word[7:0])))
        else $error("lower byte not second with order high");

    oe_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!cs_fall && !cs_rise)
        |=> $stable(result_bus_oe) && $stable(first_channel_flag_oe))
        else $error("output enable moved outside frame edges");

    data_hold_a: assert property (@(posedge clk) disable iff (rst)
        !rd_fall |=> $stable(result_bus))
        else $error("result bus moved without read edge");

    flag_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!rd_fall && !cs_fall && !cs_rise)
        |=> $stable(first_channel_flag))
        else $error("flag moved without strobe edge");

    ptr_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!rd_fall && !cs_fall && !busy_fall) |=> $stable(q.ptr))
        else $error("pointer moved without an edge");

    serial_flag_a: assert property (@(posedge clk) disable iff (rst)
        (cs_fall && q.mode != aprr_pkg::MODE_PAR
         && q.mode != aprr_pkg::MODE_BYTE)
        |=> !first_channel_flag_oe)
        else $error("flag driven outside parallel modes");

    busy_track_a: assert property (@(posedge clk) disable iff (rst)
        busy_out == $past(q.s2.busy))
        else $error("busy output not tracking pin");

endmodule

// ### tb/aprr_conv_model.sv
`timescale 1ns/1ps
`include "aprr_map.svh"

// ============================================================
// converter model: busy pulse plus eight codes per conversion
module aprr_conv_model (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    go,
    input  wire logic [`APRR_CODE_W-1:0] code_base,
    input  wire logic [7:0]              hold,
    input  wire logic                    code_ready,
    output logic                         busy_in,
    output logic [`APRR_CODE_W-1:0]      code_data,
    output logic                         code_valid
);
    initial begin
        busy_in    = 1'b0;
        code_data  = 14'h0000;
        code_valid = 1'b0;
        forever begin
            @(posedge clk iff (go && !rst));
            #1;
            busy_in = 1'b1;
            for (int i = 0; i < `APRR_CHANNELS; i++) begin
                code_data  = code_base + 14'(i);
                code_valid = 1'b1;
                do @(posedge clk); while (code_ready !== 1'b1);
                #1;
            end
            code_valid = 1'b0;
            code_data  = ~code_data;
            repeat (hold) @(posedge clk);
            #1;
            busy_in = 1'b0;
        end
    end
endmodule

// ### tb/aprr_readout_tb.sv
`timescale 1ns/1ps
`include "aprr_map.svh"

module aprr_readout_tb;
    logic        clk, rst, cs_n, rd_n, sel_p, sel_s, order, go;
    logic [13:0] code_base, code_data;
    logic [7:0]  hold;
    logic        busy_in, code_valid, code_ready, flag, flag_oe;
    logic        busy_out, conv_overrun;
    logic [15:0] result_bus, d, e;
    logic [1:0]  result_bus_oe;
    logic        f;
    int          mismatches, tests_run, cycles;

    // ============================================================
    // design and converter model
    aprr_readout #(.TCONV_NS(4000), .FIFO_DEPTH(8)) i_aprr_readout (
        .clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
        .busy_in(busy_in), .interface_select_primary(sel_p),
        .interface_select_secondary(sel_s), .byte_order_select(order),
        .code_data(code_data), .code_valid(code_valid),
        .code_ready(code_ready), .result_bus(result_bus),
        .result_bus_oe(result_bus_oe), .first_channel_flag(flag),
        .first_channel_flag_oe(flag_oe), .busy_out(busy_out),
        .conv_overrun(conv_overrun));

    aprr_conv_model i_aprr_conv_model (
        .clk(clk), .rst(rst), .go(go), .code_base(code_base), .hold(hold),
        .code_ready(code_ready), .busy_in(busy_in),
        .code_data(code_data), .code_valid(code_valid));

    // ============================================================
    // clock and timeout
    always #25 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            $display("timeout at %0t", $time);
            give_verdict();
        end
    end

    // ============================================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic logic [15:0] word(input logic [13:0] s, input int ch);
        return {s + 14'(ch), 2'b00};
    endfunction

    task automatic set_mode(input logic p, input logic s, input logic o);
        sel_p = p;
        sel_s = s;
        order = o;
        step(6);
    endtask

    task automatic do_read(output logic [15:0] dv, output logic fv);
        rd_n = 1'b0;
        step(4);
        dv   = result_bus;
        fv   = flag;
        rd_n = 1'b1;
        step(4);
    endtask

    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        while (busy_out !== v && n < 200) begin
            step(1);
            n++;
        end
        check(busy_out, v);
    endtask

    task automatic convert(input logic [13:0] s);
        code_base = s;
        go   = 1'b1;
        step(1);
        go   = 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        step(2);
    endtask

    // ============================================================
    // test sequence
    initial begin
        clk = 1'b0; rst = 1'b1; cs_n = 1'b1; rd_n = 1'b1; go = 1'b0;
        sel_p = 1'b0; sel_s = 1'b0; order = 1'b0; code_base = 14'h0000;
        hold = 8'h14;
        mismatches = 0; tests_run = 0; cycles = 0;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        step(2);
        check(result_bus_oe, 2'h0);
        check(flag_oe, 1'b0);
        end_test("reset");

        convert(14'h0100);
        set_mode(1'b0, 1'b0, 1'b0);
        cs_n = 1'b0;
        step(4);
        check(result_bus_oe, 2'h3);
        check({flag_oe, flag}, 2'h2);
        for (int i = 0; i < 8; i++) begin
            do_read(d, f);
            check(d, word(14'h0100, i));
            check(f, i == 0);
        end
        cs_n = 1'b1;
        step(4);
        check(result_bus_oe, 2'h0);
        check(flag_oe, 1'b0);
        end_test("parallel separate");

        cs_n = 1'b0;
        rd_n = 1'b0;
        step(4);
        check(result_bus_oe, 2'h3);
        check(result_bus, word(14'h0100, 0));
        check(flag, 1'b1);
        cs_n = 1'b1;
        rd_n = 1'b1;
        step(4);
        cs_n = 1'b0;
        rd_n = 1'b0;
        step(4);
        check(result_bus, word(14'h0100, 1));
        check(flag, 1'b0);
        cs_n = 1'b1;
        rd_n = 1'b1;
        step(4);
        end_test("combined strobe");

        code_base = 14'h0200;
        go   = 1'b1;
        step(1);
        go   = 1'b0;
        wait_busy(1'b1);
        cs_n = 1'b0;
        step(4);
        do_read(d, f);
        check(d, word(14'h0100, 0));
        check(busy_out, 1'b1);
        wait_busy(1'b0);
        step(2);
        do_read(d, f);
        check(d, word(14'h0200, 0));
        check(f, 1'b1);
        cs_n = 1'b1;
        step(4);
        end_test("busy read");

        for (int o = 1; o >= 0; o--) begin
            set_mode(1'b1, 1'b1, o[0]);
            cs_n = 1'b0;
            step(4);
            check(result_bus_oe, 2'h1);
            for (int i = 0; i < 16; i++) begin
                do_read(d, f);
                e = word(14'h0200, i / 2);
                check(d, {8'h00, ((i % 2 == 0) == (o == 1)) ?
                    e[15:8] : e[7:0]});
                check(f, i < 2);
            end
            cs_n = 1'b1;
            step(4);
            check(result_bus_oe, 2'h0);
        end
        end_test("byte mode");

        for (int m = 0; m < 2; m++) begin
            set_mode(m == 0, m == 1, 1'b0);
            cs_n = 1'b0;
            step(4);
            do_read(d, f);
            check(result_bus_oe, 2'h0);
            check(flag_oe, 1'b0);
            cs_n = 1'b1;
            step(4);
        end
        check(conv_overrun, 1'b0);
        end_test("refused modes");

        hold = 8'h64;
        convert(14'h0300);
        check(conv_overrun, 1'b1);
        hold = 8'h14;
        convert(14'h0400);
        check(conv_overrun, 1'b0);
        end_test("long conversion");
        give_verdict();
    end
endmodule
